/* hw/alk_pkg.sv */
// Constants for the PLL lock detector control block.
package alk_pkg;

	// Register byte offsets.
	localparam logic [7:0] ALK_OFF_THIRD_POLE = 8'h00;
	localparam logic [7:0] ALK_OFF_LOCK_CFG   = 8'h04;
	localparam logic [7:0] ALK_OFF_THRESH     = 8'h08;
	localparam logic [7:0] ALK_OFF_STATUS     = 8'h0C;
	localparam logic [7:0] ALK_OFF_EVENT      = 8'h10;
	localparam logic [7:0] ALK_OFF_MASK       = 8'h14;

	// Third pole register fields.
	localparam int ALK_TP_BYP_BIT = 7;
	localparam int ALK_TP_RES_LSB = 4;
	localparam int ALK_TP_CAP_LSB = 0;

	// Lock detector configuration fields.
	localparam int ALK_LC_RAW_PIN_BIT = 9;
	localparam int ALK_LC_PREC_EN_BIT = 8;
	localparam int ALK_LC_TIMER_LSB   = 6;
	localparam int ALK_LC_STICKY_BIT  = 5;
	localparam int ALK_LC_CALBYP_BIT  = 4;
	localparam int ALK_LC_DISABLE_BIT = 3;
	localparam int ALK_LC_FILT_LSB    = 0;

	// Threshold register fields.
	localparam int ALK_TH_HIGH_LSB = 4;
	localparam int ALK_TH_LOW_LSB  = 0;

	// Status and event bit positions.
	localparam int ALK_ST_LOCK_BIT   = 0;
	localparam int ALK_ST_RAW_BIT    = 1;
	localparam int ALK_ST_CAL_BIT    = 2;
	localparam int ALK_ST_DETEN_BIT  = 3;
	localparam int ALK_EV_LOL_BIT    = 0;

	// Reset values.
	localparam logic [2:0] ALK_RST_TP_RES  = 3'h3;
	localparam logic [2:0] ALK_RST_TP_CAP  = 3'h7;
	localparam logic       ALK_RST_PREC_EN = 1'h1;
	localparam logic [1:0] ALK_RST_TIMER   = 2'h2;
	localparam logic [2:0] ALK_RST_FILT    = 3'h0;
	localparam logic [3:0] ALK_RST_TH_HIGH = 4'h8;
	localparam logic [3:0] ALK_RST_TH_LOW  = 4'h8;

	// Debounce intervals in system clock cycles.
	localparam logic [15:0] ALK_TIMER_CYC_1 = 16'h023A;
	localparam logic [15:0] ALK_TIMER_CYC_2 = 16'h1644;
	localparam logic [15:0] ALK_TIMER_CYC_3 = 16'hDEA8;

	// Debounce qualifier states.
	typedef enum logic [2:0] {
		ALK_DEB_OFF  = 3'b001,
		ALK_DEB_WAIT = 3'b010,
		ALK_DEB_LOCK = 3'b100
	} alk_deb_state_e;

endpackage

/* hw/alk_deb_if.sv */
// Link between the control top and the lock debounce qualifier.
`timescale 1ns/1ps
`default_nettype none
interface alk_deb_if;
	logic       raw_lock;
	logic       det_enable;
	logic [1:0] timer_code;
	logic       qualified;

	modport ctl (output raw_lock, output det_enable, output timer_code, input qualified);
	modport deb (input raw_lock, input det_enable, input timer_code, output qualified);
endinterface
`default_nettype wire

/* hw/alk_debounce.sv */
// Lock debounce qualifier: raw lock must stay high for the chosen interval.
`timescale 1ns/1ps
`default_nettype none
module alk_debounce
	import alk_pkg::*;
#(
	parameter logic [15:0] TIMER_CYC_2 = ALK_TIMER_CYC_2,
	parameter logic [15:0] TIMER_CYC_3 = ALK_TIMER_CYC_3
) (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Qualifier link.
	alk_deb_if.deb    dl
);
	alk_deb_state_e state;
	alk_deb_state_e next_state;
	logic [15:0]    count;
	logic [15:0]    next_count;
	logic [15:0]    interval;
	wire            raw_ok = dl.raw_lock & dl.det_enable;

	assign interval = (dl.timer_code == 2'h0) ? 16'h0000 :
	                  (dl.timer_code == 2'h1) ? ALK_TIMER_CYC_1 :
	                  (dl.timer_code == 2'h2) ? TIMER_CYC_2 : TIMER_CYC_3;

	// A drop of the raw lock restarts the interval from zero.
	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			ALK_DEB_OFF: begin
				next_count = 16'h0000;
				if (raw_ok && interval == 16'h0000) begin
					next_state = ALK_DEB_LOCK;
				end else if (raw_ok) begin
					next_state = ALK_DEB_WAIT;
					next_count = 16'h0001;
				end
			end
			ALK_DEB_WAIT: begin
				if (!raw_ok) begin
					next_state = ALK_DEB_OFF;
					next_count = 16'h0000;
				end else if (count >= interval) begin
					next_state = ALK_DEB_LOCK;
				end else begin
					next_count = count + 16'h0001;
				end
			end
			ALK_DEB_LOCK: begin
				if (!raw_ok) begin
					next_state = ALK_DEB_OFF;
					next_count = 16'h0000;
				end
			end
			default: begin
				next_state = ALK_DEB_OFF;
				next_count = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ALK_DEB_OFF;
			count <= 16'h0000;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	assign dl.qualified = (state == ALK_DEB_LOCK);
endmodule
`default_nettype wire

/* hw/alk_lock_ctrl.sv */
// PLL lock detector control: registers, lock qualification and status pin.
//
// What this block does
// - Third-pole resistor select sits in bits 6:4, resets to 0x3.
// - Third-pole capacitor select sits in bits 2:0, resets to 0x7.
// - Raw-lock-to-pin bit routes the undebounced selected lock to the status pin.
// - Precision detector enable, reset one, selects the precision lock source.
// - Debounce code 0..3 gives 0, 570, 5700, 57000 cycles; resets to 2.
// - Sticky lock select holds qualified lock after its first assertion.
// - Without calibration bypass, detection waits for VCO calibration done.
// - Detector-disable bit forces the lock signal asserted.
// - Lock detect filter resistor select, three bits, resets to zero.
// - Precision high threshold in bits 7:4 resets to 0x8.
// - Precision low threshold in bits 3:0 resets to 0x8.
// - Locked-to-unlocked transition sets sticky loss-of-lock flag, write one clears.
// - Calibration done reads zero during calibration, one after; it gates detection.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module alk_lock_ctrl
	import alk_pkg::*;
#(
	parameter logic [15:0] TIMER_CYC_2 = ALK_TIMER_CYC_2,
	parameter logic [15:0] TIMER_CYC_3 = ALK_TIMER_CYC_3
) (
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// APB slave.
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]     prdata,
	output logic            pready,
	output logic            pslverr,
	// Analog lock comparators and calibration status.
	input  wire logic       orig_lock_raw,
	input  wire logic       precision_lock_raw,
	input  wire logic       vco_cal_done,
	// Analog configuration outputs.
	output logic            third_pole_bypass,
	output logic [2:0]      third_pole_resistor_sel,
	output logic [2:0]      third_pole_capacitor_sel,
	output logic            precision_detector_en,
	output logic [2:0]      lock_filter_res_sel,
	output logic [3:0]      precision_high_threshold,
	output logic [3:0]      precision_low_threshold,
	output logic            lock_detect_enable,
	// Status pin and interrupt.
	output logic            lock_status_pin,
	output logic            irq
);

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		hit = (addr == offset);
	endfunction

	// Configuration registers.
	logic       tp_bypass;
	logic [2:0] tp_res;
	logic [2:0] tp_cap;
	logic       raw_to_pin;
	logic       prec_en;
	logic [1:0] timer_code;
	logic       sticky_sel;
	logic       cal_bypass;
	logic       det_disable;
	logic [2:0] filt_sel;
	logic [3:0] th_high;
	logic [3:0] th_low;
	logic       evt_lol;
	logic       mask_lol;

	// Synchronisers for the analog inputs.
	logic [1:0] orig_sync;
	logic [1:0] prec_sync;
	logic [1:0] cal_sync;

	// Lock path state.
	logic       sticky_hold;
	logic       lock_prev;

	alk_deb_if deb_link ();

	// Bus decode.
	wire        setup_ph    = psel & ~penable;
	wire        access_ph   = psel & penable;
	wire        wr_en       = access_ph & pwrite;
	wire        sel_tp      = hit(paddr, ALK_OFF_THIRD_POLE);
	wire        sel_lc      = hit(paddr, ALK_OFF_LOCK_CFG);
	wire        sel_th      = hit(paddr, ALK_OFF_THRESH);
	wire        sel_st      = hit(paddr, ALK_OFF_STATUS);
	wire        sel_ev      = hit(paddr, ALK_OFF_EVENT);
	wire        sel_mk      = hit(paddr, ALK_OFF_MASK);
	wire        mapped      = sel_tp | sel_lc | sel_th | sel_st | sel_ev | sel_mk;

	// Lock path signals.
	wire        orig_s      = orig_sync[1];
	wire        prec_s      = prec_sync[1];
	wire        cal_done_s  = cal_sync[1];
	wire        raw_sel     = prec_en ? prec_s : orig_s;
	wire        det_en      = cal_bypass | cal_done_s;
	wire        deb_lock    = deb_link.qualified;
	wire        lock_now    = det_disable | deb_lock | sticky_hold;
	wire        lol_set     = lock_prev & ~lock_now;
	wire        lol_clr     = wr_en & sel_ev & pwdata[ALK_EV_LOL_BIT];

	// Read data assembled per register.
	wire [31:0] rd_tp = {24'h000000, tp_bypass, tp_res, 1'b0, tp_cap};
	wire [31:0] rd_lc = {22'h0, raw_to_pin, prec_en, timer_code, sticky_sel,
	                     cal_bypass, det_disable, filt_sel};
	wire [31:0] rd_th = {24'h000000, th_high, th_low};
	wire [31:0] rd_st = {28'h0000000, det_en, cal_done_s, raw_sel, lock_now};
	wire [31:0] rd_ev = {31'h0, evt_lol};
	wire [31:0] rd_mk = {31'h0, mask_lol};
	wire [31:0] rd_mux = sel_tp ? rd_tp :
	                     sel_lc ? rd_lc :
	                     sel_th ? rd_th :
	                     sel_st ? rd_st :
	                     sel_ev ? rd_ev :
	                     sel_mk ? rd_mk : 32'h00000000;

	// Qualifier hookup.
	assign deb_link.raw_lock   = raw_sel;
	assign deb_link.det_enable = det_en & ~det_disable;
	assign deb_link.timer_code = timer_code;

	alk_debounce #(
		.TIMER_CYC_2 (TIMER_CYC_2),
		.TIMER_CYC_3 (TIMER_CYC_3)
	) u_debounce (
		.pclk    (pclk),
		.presetn (presetn),
		.dl      (deb_link)
	);

	// Two flip-flops before any logic reads an analog input.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			orig_sync <= 2'h0;
			prec_sync <= 2'h0;
			cal_sync  <= 2'h0;
		end else begin
			orig_sync <= {orig_sync[0], orig_lock_raw};
			prec_sync <= {prec_sync[0], precision_lock_raw};
			cal_sync  <= {cal_sync[0], vco_cal_done};
		end
	end

	// Third pole register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tp_bypass <= 1'b0;
			tp_res    <= ALK_RST_TP_RES;
			tp_cap    <= ALK_RST_TP_CAP;
		end else if (wr_en && sel_tp) begin
			tp_bypass <= pwdata[ALK_TP_BYP_BIT];
			tp_res    <= pwdata[ALK_TP_RES_LSB +: 3];
			tp_cap    <= pwdata[ALK_TP_CAP_LSB +: 3];
		end
	end

	// Lock detector configuration register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_to_pin  <= 1'b0;
			prec_en     <= ALK_RST_PREC_EN;
			timer_code  <= ALK_RST_TIMER;
			sticky_sel  <= 1'b0;
			cal_bypass  <= 1'b0;
			det_disable <= 1'b0;
			filt_sel    <= ALK_RST_FILT;
		end else if (wr_en && sel_lc) begin
			raw_to_pin  <= pwdata[ALK_LC_RAW_PIN_BIT];
			prec_en     <= pwdata[ALK_LC_PREC_EN_BIT];
			timer_code  <= pwdata[ALK_LC_TIMER_LSB +: 2];
			sticky_sel  <= pwdata[ALK_LC_STICKY_BIT];
			cal_bypass  <= pwdata[ALK_LC_CALBYP_BIT];
			det_disable <= pwdata[ALK_LC_DISABLE_BIT];
			filt_sel    <= pwdata[ALK_LC_FILT_LSB +: 3];
		end
	end

	// Precision threshold register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			th_high <= ALK_RST_TH_HIGH;
			th_low  <= ALK_RST_TH_LOW;
		end else if (wr_en && sel_th) begin
			th_high <= pwdata[ALK_TH_HIGH_LSB +: 4];
			th_low  <= pwdata[ALK_TH_LOW_LSB +: 4];
		end
	end

	// Mask register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_lol <= 1'b0;
		end else if (wr_en && sel_mk) begin
			mask_lol <= pwdata[ALK_EV_LOL_BIT];
		end
	end

	// A new loss of lock in the clearing cycle keeps the flag set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_lol <= 1'b0;
		end else begin
			evt_lol <= lol_set | (evt_lol & ~lol_clr);
		end
	end

	// Sticky hold and the previous lock value for edge detection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky_hold <= 1'b0;
			lock_prev   <= 1'b0;
		end else begin
			sticky_hold <= sticky_sel & (sticky_hold | deb_lock);
			lock_prev   <= lock_now;
		end
	end

	// Read data is captured in the setup phase so it stands from a register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup_ph && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// The pin carries either the raw selected lock or the qualified lock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_status_pin <= 1'b0;
		end else begin
			lock_status_pin <= raw_to_pin ? raw_sel : lock_now;
		end
	end

	assign pready                   = 1'b1;
	assign pslverr                  = access_ph & ~mapped;
	assign irq                      = evt_lol & mask_lol;
	assign third_pole_bypass        = tp_bypass;
	assign third_pole_resistor_sel  = tp_res;
	assign third_pole_capacitor_sel = tp_cap;
	assign precision_detector_en    = prec_en;
	assign lock_filter_res_sel      = filt_sel;
	assign precision_high_threshold = th_high;
	assign precision_low_threshold  = th_low;
	assign lock_detect_enable       = det_en & ~det_disable;

endmodule
`default_nettype wire

/* test/alk_lock_ctrl_checker.sv */
// Port-level checks of the lock control block.
`timescale 1ns/1ps
`default_nettype none
module alk_lock_ctrl_checker
	import alk_pkg::*;
(
	// Clock, reset and bus.
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	// Configuration and interrupt.
	input wire logic        third_pole_bypass,
	input wire logic [2:0]  third_pole_resistor_sel,
	input wire logic [2:0]  third_pole_capacitor_sel,
	input wire logic        precision_detector_en,
	input wire logic [2:0]  lock_filter_res_sel,
	input wire logic [3:0]  precision_high_threshold,
	input wire logic [3:0]  precision_low_threshold,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic       wr = psel && penable && pwrite;
	wire logic [7:0] tp = {third_pole_bypass, third_pole_resistor_sel, 1'b0, third_pole_capacitor_sel};
	wire logic [7:0] th = {precision_high_threshold, precision_low_threshold};
	wire logic [3:0] lc = {precision_detector_en, lock_filter_res_sel};

	property p_rst_tp;
		$rose(presetn) |-> tp == {1'b0, ALK_RST_TP_RES, 1'b0, ALK_RST_TP_CAP};
	endproperty
	a_rst_tp: assert property (p_rst_tp) else $error("third pole reset value wrong");
	property p_rst_lc;
		$rose(presetn) |-> lc == {ALK_RST_PREC_EN, ALK_RST_FILT};
	endproperty
	a_rst_lc: assert property (p_rst_lc) else $error("lock config reset value wrong");
	property p_rst_th;
		$rose(presetn) |-> th == {ALK_RST_TH_HIGH, ALK_RST_TH_LOW};
	endproperty
	a_rst_th: assert property (p_rst_th) else $error("threshold reset value wrong");
	property p_tp_wr;
		wr && paddr == ALK_OFF_THIRD_POLE |=> tp == ($past(pwdata[7:0]) & 8'hF7);
	endproperty
	a_tp_wr: assert property (p_tp_wr) else $error("third pole write lost");
	property p_th_wr;
		wr && paddr == ALK_OFF_THRESH |=> th == $past(pwdata[7:0]);
	endproperty
	a_th_wr: assert property (p_th_wr) else $error("threshold write lost");
	property p_lc_wr;
		wr && paddr == ALK_OFF_LOCK_CFG |=> lc == {$past(pwdata[8]), $past(pwdata[2:0])};
	endproperty
	a_lc_wr: assert property (p_lc_wr) else $error("lock config write lost");
	property p_hold;
		!wr |=> $stable(tp) && $stable(th) && $stable(lc);
	endproperty
	a_hold: assert property (p_hold) else $error("configuration moved without a write");
	property p_irq;
		irq && !wr |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt dropped without a write");
endmodule
bind alk_lock_ctrl alk_lock_ctrl_checker alk_lock_ctrl_checker_i (.*);
`default_nettype wire

/* test/alk_pll_model.sv */
// Behavioural analog lock comparators and calibration engine.
`timescale 1ns/1ps
`default_nettype none
module alk_pll_model (
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Bench controls.
	input  wire logic       orig_tgt,
	input  wire logic       prec_tgt,
	input  wire logic       cal_tgt,
	input  wire logic [7:0] settle,
	// Comparator and calibration outputs.
	output logic            orig_lock_raw,
	output logic            precision_lock_raw,
	output logic            vco_cal_done
);
	logic [7:0] cnt;
	// The precision comparator trips only once its filter has settled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
		end else begin
			cnt <= !prec_tgt ? 8'h00 : (cnt == settle ? cnt : cnt + 8'h01);
		end
	end
	assign precision_lock_raw = prec_tgt && cnt == settle;
	assign orig_lock_raw = orig_tgt;
	assign vco_cal_done = cal_tgt;
endmodule
`default_nettype wire

/* test/test_alk_lock_ctrl.sv */
// Register and lock path tests of the lock control block.
`timescale 1ns/1ps
`default_nettype none
module test_alk_lock_ctrl;
	import alk_pkg::*;
	localparam int C2 = 20;
	localparam int C3 = 40;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic orig_lock_raw, precision_lock_raw, vco_cal_done, orig_tgt, prec_tgt, cal_tgt;
	logic third_pole_bypass, precision_detector_en, lock_detect_enable, lock_status_pin;
	logic [2:0] third_pole_resistor_sel, third_pole_capacitor_sel, lock_filter_res_sel;
	logic [3:0] precision_high_threshold, precision_low_threshold;
	logic [7:0] paddr, settle;
	logic [31:0] pwdata, prdata, q;
	int n_fail, checked, cyc, n;
	int iv[4] = '{0, 570, C2, C3};
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end

	alk_lock_ctrl #(.TIMER_CYC_2(16'(C2)), .TIMER_CYC_3(16'(C3))) alk_lock_ctrl_i (.*);
	alk_pll_model alk_pll_model_i (.*);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// One APB transfer; it returns right after the completing edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask

	// Waits on falling edges, where the pin has settled, never at the launching edge.
	task automatic wpin(input logic e, input int lim);
		n = 0;
		@(negedge pclk);
		while (lock_status_pin !== e && n < lim) begin
			@(negedge pclk);
			n++;
		end
	endtask

	initial begin
		{presetn, psel, penable, pwrite, orig_tgt, prec_tgt, cal_tgt} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		settle = 8'h00;
		n_fail = 0;
		checked = 0;
		cyc = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ALK_OFF_THIRD_POLE, 32'h37);
		rdc(ALK_OFF_LOCK_CFG, 32'h180);
		rdc(ALK_OFF_THRESH, 32'h88);
		apb(1'b1, ALK_OFF_THIRD_POLE, 32'hFF);
		rdc(ALK_OFF_THIRD_POLE, 32'hF7);
		apb(1'b1, ALK_OFF_THRESH, 32'h3C);
		rdc(ALK_OFF_THRESH, 32'h3C);
		`CHK(err, 1'b0)
		rdc(8'h18, 32'h0);
		`CHK(err, 1'b1)
		$display("test registers done");
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, ALK_OFF_LOCK_CFG, {22'h0, 2'b01, 2'(c), 6'h10});
			prec_tgt <= 1'b1;
			repeat (iv[c] / 2 + 1) @(posedge pclk);
			prec_tgt <= 1'b0;
			repeat (4) @(posedge pclk);
			prec_tgt <= 1'b1;
			wpin(1'b1, iv[c] + 20);
			`CHK(n >= iv[c] && n <= iv[c] + 8, 1'b1)
			@(posedge pclk);
			prec_tgt <= 1'b0;
			wpin(1'b0, 20);
		end
		$display("test debounce done");
		orig_tgt <= 1'b1;
		settle <= 8'd30;
		apb(1'b1, ALK_OFF_LOCK_CFG, 32'h110);
		prec_tgt <= 1'b1;
		wpin(1'b1, 50);
		`CHK(n >= 30 && n <= 40, 1'b1)
		apb(1'b1, ALK_OFF_LOCK_CFG, 32'h100);
		repeat (12) @(negedge pclk);
		`CHK(lock_detect_enable, 1'b0)
		`CHK(lock_status_pin, 1'b0)
		@(posedge pclk);
		cal_tgt <= 1'b1;
		wpin(1'b1, 12);
		`CHK(lock_status_pin, 1'b1)
		rdc(ALK_OFF_STATUS, 32'hF);
		apb(1'b1, ALK_OFF_EVENT, 32'h1);
		rdc(ALK_OFF_EVENT, 32'h0);
		$display("test source and gating done");
		apb(1'b1, ALK_OFF_MASK, 32'h1);
		prec_tgt <= 1'b0;
		wpin(1'b0, 12);
		`CHK(irq, 1'b1)
		rdc(ALK_OFF_EVENT, 32'h1);
		prec_tgt <= 1'b1;
		wpin(1'b1, 50);
		`CHK(lock_status_pin, 1'b1)
		apb(1'b1, ALK_OFF_MASK, 32'h0);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		apb(1'b1, ALK_OFF_EVENT, 32'h1);
		rdc(ALK_OFF_EVENT, 32'h0);
		$display("test loss of lock done");
		apb(1'b1, ALK_OFF_LOCK_CFG, 32'h130);
		prec_tgt <= 1'b0;
		wpin(1'b0, 12);
		`CHK(lock_status_pin, 1'b1)
		apb(1'b1, ALK_OFF_LOCK_CFG, 32'h108);
		wpin(1'b0, 12);
		`CHK(lock_status_pin, 1'b1)
		apb(1'b1, ALK_OFF_LOCK_CFG, 32'h3D0);
		wpin(1'b0, 12);
		@(posedge pclk);
		prec_tgt <= 1'b1;
		settle <= 8'h00;
		wpin(1'b1, 12);
		`CHK(n < 12, 1'b1)
		$display("test sticky, disable and raw pin done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ALK_OFF_LOCK_CFG, 32'h180);
		$display("test second reset done");
		finish_test();
	end
endmodule
`default_nettype wire
